// >>> src/cccb_map.svh
// register offsets, status bit positions and fixed constants of the core slice
`ifndef CCCB_MAP_SVH
`define CCCB_MAP_SVH
`define CCCB_CMD_OFF 12'h000
`define CCCB_SRCX_OFF 12'h004
`define CCCB_DSTX_OFF 12'h008
`define CCCB_STAT_OFF 12'h00c
`define CCCB_REG_PAGE 6'h01
`define CCCB_STAT_BUSY 16
`define CCCB_PC 4'h0
`define CCCB_SP 4'h1
`define CCCB_SR 4'h2
`define CCCB_SR_C 0
`define CCCB_SR_Z 1
`define CCCB_SR_N 2
`define CCCB_SR_V 8
`define CCCB_MODE_LO 3
`define CCCB_MODE_HI 5
`define CCCB_MASK_C 20'h00001
`define CCCB_MASK_Z 20'h00002
`define CCCB_MASK_N 20'h00004
`define CCCB_WORD_STEP 20'h00002
`define CCCB_BYTE_STEP 20'h00001
`define CCCB_BCD_MAX 5'h09
`define CCCB_BCD_ADJ 5'h06
`endif

// >>> src/cccb_pkg.sv
// types shared by the call/compare/decimal core slice
package cccb_pkg;
  typedef enum logic [3:0] {
    op_none, op_unconditional_jump, op_call, op_zero_destination,
    op_carry_flag_reset_op, op_sign_flag_reset_op, op_equal_flag_reset_op,
    op_compare_op, op_decimal_carry_add, op_decimal_sum_op
  } cccb_op_t;
  typedef enum logic [2:0] {
    sm_reg, sm_indexed, sm_symbolic, sm_absolute, sm_indirect, sm_autoinc, sm_immediate
  } cccb_src_mode_t;
  typedef struct packed {
    logic dst_mem;
    logic [3:0] dst_reg;
    logic [3:0] src_reg;
    cccb_src_mode_t src_mode;
    logic byte_op;
    cccb_op_t op;
  } cccb_cmd_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic we;
  } cccb_mem_t;
  typedef enum logic [2:0] {
    st_idle, st_dec, st_src, st_dst, st_exec, st_push, st_write
  } cccb_state_t;
endpackage

// >>> src/cccb_core.sv
// execution slice: jump, call, clear, flag clears, compare and decimal add
`timescale 1ns/1ps
`include "cccb_map.svh"
module cccb_core
  import cccb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_valid,
  output cccb_mem_t mem_req,
  input wire logic mem_ready,
  input wire logic [15:0] mem_rdata,
  output logic busy
);
  cccb_state_t state, next_state;
  cccb_cmd_t cmd;
  cccb_mem_t next_req;
  logic [19:0] regs [16];
  logic [15:0] srcx, dstx, tmp, dval, dop, src_now, res, bcd_res, rd_val;
  logic [19:0] src_addr, dst_addr;
  logic [31:0] rd_mux;
  logic [16:0] cw;
  logic [8:0] cb;
  logic uses_src, src_mem, need_dst, writes_dst, new_c, new_v, new_z, new_n;
  logic reg_hit, map_hit, wr_ok, byte_sz;
  wire [4:0] bc;

  //////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign busy = state != st_idle;
  assign reg_hit = paddr[11:6] == `CCCB_REG_PAGE && paddr[1:0] == 2'h0;
  assign map_hit = reg_hit || paddr inside {`CCCB_CMD_OFF, `CCCB_SRCX_OFF,
                                            `CCCB_DSTX_OFF, `CCCB_STAT_OFF};
  // writes while an operation runs are refused so operands cannot shift under it
  assign wr_ok = psel && penable && pwrite && map_hit && !busy;
  assign pslverr = psel && penable && (!map_hit || (pwrite && busy));

  always_comb begin
    rd_mux = 32'h0;
    if (reg_hit) begin
      rd_mux = {12'h0, regs[paddr[5:2]]};
    end else begin
      case (paddr)
        `CCCB_CMD_OFF: rd_mux = {15'h0, cmd};
        `CCCB_SRCX_OFF: rd_mux = {16'h0, srcx};
        `CCCB_DSTX_OFF: rd_mux = {16'h0, dstx};
        `CCCB_STAT_OFF: begin
          rd_mux = {16'h0, regs[`CCCB_SR][15:0]};
          rd_mux[`CCCB_STAT_BUSY] = busy;
        end
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
      srcx <= 16'h0;
      dstx <= 16'h0;
    end else if (wr_ok) begin
      if (paddr == `CCCB_CMD_OFF) cmd <= cccb_cmd_t'(pwdata[16:0]);
      if (paddr == `CCCB_SRCX_OFF) srcx <= pwdata[15:0];
      if (paddr == `CCCB_DSTX_OFF) dstx <= pwdata[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // operand decode
  always_comb begin
    uses_src = cmd.op inside {op_unconditional_jump, op_call, op_compare_op,
                              op_decimal_sum_op};
    src_mem = uses_src && cmd.src_mode inside {sm_indexed, sm_symbolic, sm_absolute,
                                               sm_indirect, sm_autoinc};
    need_dst = cmd.dst_mem && cmd.op inside {op_compare_op, op_decimal_carry_add,
                                             op_decimal_sum_op};
    writes_dst = cmd.op inside {op_zero_destination, op_decimal_carry_add,
                                op_decimal_sum_op};
  end

  always_comb begin
    case (cmd.src_mode)
      sm_indexed: src_addr = regs[cmd.src_reg] + {{4{srcx[15]}}, srcx};
      sm_symbolic: src_addr = regs[`CCCB_PC] + {{4{srcx[15]}}, srcx};
      sm_absolute: src_addr = {4'h0, srcx};
      default: src_addr = regs[cmd.src_reg];
    endcase
    if (!uses_src) begin
      src_now = 16'h0;
    end else if (cmd.src_mode == sm_immediate) begin
      src_now = srcx;
    end else begin
      src_now = regs[cmd.src_reg][15:0];
    end
  end

  assign dst_addr = regs[cmd.dst_reg] + {{4{dstx[15]}}, dstx};
  assign dop = cmd.dst_mem ? dval : regs[cmd.dst_reg][15:0];
  // jump and call are word operations whatever the size bit says
  assign byte_sz = cmd.byte_op && !(cmd.op inside {op_unconditional_jump, op_call});
  assign rd_val = !byte_sz ? mem_rdata :
                  {8'h0, mem_req.addr[0] ? mem_rdata[15:8] : mem_rdata[7:0]};

  //////////////////////////////////////////////////////////////////////////////
  // arithmetic
  // carry enters the lowest digit; byte results take the carry out of digit 1
  assign bc[0] = regs[`CCCB_SR][`CCCB_SR_C];
  for (genvar gi = 0; gi < 4; gi++) begin : g_digit
    logic [4:0] dsum;
    assign dsum = {1'b0, dop[4*gi+:4]} + {1'b0, tmp[4*gi+:4]} + {4'h0, bc[gi]};
    assign bc[gi+1] = dsum > `CCCB_BCD_MAX;
    // non-bcd digits simply run through the same adjust, result meaningless
    assign bcd_res[4*gi+:4] = bc[gi+1] ? 4'(dsum + `CCCB_BCD_ADJ) : dsum[3:0];
  end

  assign cw = {1'b0, dop} + {1'b0, ~tmp} + 17'h1;
  assign cb = {1'b0, dop[7:0]} + {1'b0, ~tmp[7:0]} + 9'h1;

  always_comb begin
    res = 16'h0;
    new_c = regs[`CCCB_SR][`CCCB_SR_C];
    new_v = regs[`CCCB_SR][`CCCB_SR_V];
    case (cmd.op)
      op_compare_op: begin
        res = cmd.byte_op ? {8'h0, cb[7:0]} : cw[15:0];
        new_c = cmd.byte_op ? cb[8] : cw[16];
        if (cmd.byte_op) begin
          new_v = (dop[7] != tmp[7]) && (cb[7] != dop[7]);
        end else begin
          new_v = (dop[15] != tmp[15]) && (cw[15] != dop[15]);
        end
      end
      op_decimal_carry_add, op_decimal_sum_op: begin
        res = cmd.byte_op ? {8'h0, bcd_res[7:0]} : bcd_res;
        // overflow is undefined here; it is simply left as it was
        new_c = cmd.byte_op ? bc[2] : bc[4];
      end
      default: res = 16'h0;
    endcase
    new_z = cmd.byte_op ? res[7:0] == 8'h0 : res == 16'h0;
    new_n = cmd.byte_op ? res[7] : res[15];
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    next_state = state;
    case (state)
      st_idle: if (wr_ok && paddr == `CCCB_CMD_OFF) next_state = st_dec;
      st_dec: next_state = src_mem ? st_src : (need_dst ? st_dst : st_exec);
      st_src: if (mem_ready) next_state = need_dst ? st_dst : st_exec;
      st_dst: if (mem_ready) next_state = st_exec;
      st_exec: begin
        if (cmd.op == op_call) begin
          next_state = st_push;
        end else if (writes_dst && cmd.dst_mem) begin
          next_state = st_write;
        end else begin
          next_state = st_idle;
        end
      end
      st_push, st_write: if (mem_ready) next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_req = '0;
    next_req.be = 2'b11;
    case (next_state)
      st_src: next_req.addr = src_addr;
      st_dst: next_req.addr = dst_addr;
      st_push: begin
        next_req.addr = regs[`CCCB_SP] - `CCCB_WORD_STEP;
        next_req.wdata = regs[`CCCB_PC][15:0];
        next_req.we = 1'b1;
      end
      st_write: begin
        next_req.addr = dst_addr;
        next_req.wdata = cmd.byte_op ? {res[7:0], res[7:0]} : res;
        next_req.we = 1'b1;
      end
      default: next_req.addr = 20'h0;
    endcase
    if (byte_sz && next_state inside {st_src, st_dst, st_write}) begin
      next_req.be = next_req.addr[0] ? 2'b10 : 2'b01;
    end
  end

  // request is loaded only on a state change so it holds while the memory stalls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= '0;
    end else if (next_state != state) begin
      mem_req <= next_req;
    end
  end

  assign mem_valid = state inside {st_src, st_dst, st_push, st_write};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmp <= 16'h0;
      dval <= 16'h0;
    end else begin
      if (state == st_dec) tmp <= src_now;
      if (state == st_src && mem_ready) tmp <= rd_val;
      if (state == st_dst && mem_ready) dval <= rd_val;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file: pc, sp, status word and general registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) regs[i] <= 20'h0;
    end else begin
      if (wr_ok && reg_hit) regs[paddr[5:2]] <= pwdata[19:0];
      if (state == st_src && mem_ready && cmd.src_mode == sm_autoinc) begin
        regs[cmd.src_reg] <= regs[cmd.src_reg] +
                             (byte_sz ? `CCCB_BYTE_STEP : `CCCB_WORD_STEP);
      end
      if (state == st_exec) begin
        // flag writes touch only c, z, n, v; mode bits stay put
        case (cmd.op)
          op_unconditional_jump: regs[`CCCB_PC] <= {4'h0, tmp};
          op_call: regs[`CCCB_SP] <= regs[`CCCB_SP] - `CCCB_WORD_STEP;
          op_carry_flag_reset_op: regs[`CCCB_SR] <= regs[`CCCB_SR] & ~`CCCB_MASK_C;
          op_sign_flag_reset_op: regs[`CCCB_SR] <= regs[`CCCB_SR] & ~`CCCB_MASK_N;
          op_equal_flag_reset_op: regs[`CCCB_SR] <= regs[`CCCB_SR] & ~`CCCB_MASK_Z;
          op_compare_op: begin
            // destination register untouched, upper bits included
            regs[`CCCB_SR][`CCCB_SR_C] <= new_c;
            regs[`CCCB_SR][`CCCB_SR_Z] <= new_z;
            regs[`CCCB_SR][`CCCB_SR_N] <= new_n;
            regs[`CCCB_SR][`CCCB_SR_V] <= new_v;
          end
          op_zero_destination, op_decimal_carry_add, op_decimal_sum_op: begin
            if (!cmd.dst_mem) begin
              regs[cmd.dst_reg] <= cmd.byte_op ? {12'h0, res[7:0]} : {4'h0, res};
            end
            if (cmd.op != op_zero_destination) begin
              regs[`CCCB_SR][`CCCB_SR_C] <= new_c;
              regs[`CCCB_SR][`CCCB_SR_Z] <= new_z;
              regs[`CCCB_SR][`CCCB_SR_N] <= new_n;
            end
          end
          default: regs[`CCCB_PC] <= regs[`CCCB_PC];
        endcase
      end
      if (state == st_push && mem_ready) regs[`CCCB_PC] <= {4'h0, tmp};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_call_pc_load: assert property (
    state == st_push && mem_ready |=> regs[`CCCB_PC] == {4'h0, $past(tmp)})
    else $error("call did not load 16-bit target into pc");
  a_call_sp_dec: assert property (
    state == st_exec && cmd.op == op_call
    |=> state == st_push && regs[`CCCB_SP] == $past(regs[`CCCB_SP]) - `CCCB_WORD_STEP)
    else $error("call did not decrement sp by two before push");
  a_push_at_tos: assert property (
    state == st_push |-> mem_req.we && mem_req.addr == regs[`CCCB_SP])
    else $error("return address not written at top of stack");
  a_call_flags_kept: assert property (
    state inside {st_exec, st_push} && cmd.op == op_call
    |=> regs[`CCCB_SR] == $past(regs[`CCCB_SR]))
    else $error("call altered status word");
  a_autoinc_step: assert property (
    state == st_src && mem_ready && cmd.src_mode == sm_autoinc && !cmd.byte_op
    && cmd.src_reg != `CCCB_PC
    |=> regs[cmd.src_reg] == $past(regs[cmd.src_reg]) + `CCCB_WORD_STEP)
    else $error("word autoincrement pointer not advanced by two");
  a_carry_flag_reset_op_only: assert property (
    state == st_exec && cmd.op == op_carry_flag_reset_op
    |=> regs[`CCCB_SR] == ($past(regs[`CCCB_SR]) & ~`CCCB_MASK_C))
    else $error("carry reset touched other bits");
  a_sign_flag_reset_op_only: assert property (
    state == st_exec && cmd.op == op_sign_flag_reset_op
    |=> regs[`CCCB_SR] == ($past(regs[`CCCB_SR]) & ~`CCCB_MASK_N))
    else $error("sign reset touched other bits");
  a_equal_flag_reset_op_only: assert property (
    state == st_exec && cmd.op == op_equal_flag_reset_op
    |=> regs[`CCCB_SR] == ($past(regs[`CCCB_SR]) & ~`CCCB_MASK_Z))
    else $error("equal reset touched other bits");
  a_cmp_no_write: assert property (
    state == st_write |-> cmd.op != op_compare_op)
    else $error("compare wrote its destination");
  a_cmp_zero_flag: assert property (
    state == st_exec && cmd.op == op_compare_op && !cmd.byte_op
    |=> regs[`CCCB_SR][`CCCB_SR_Z] == ($past(dop) == $past(tmp)))
    else $error("compare zero flag does not match equality");
  a_bcd_wrap: assert property (
    state == st_exec && cmd.op == op_decimal_carry_add && !cmd.byte_op && cmd.dst_mem
    && dop == 16'h9999 && regs[`CCCB_SR][`CCCB_SR_C]
    |=> regs[`CCCB_SR][`CCCB_SR_C] && regs[`CCCB_SR][`CCCB_SR_Z] && mem_req.wdata == 16'h0)
    else $error("decimal wrap from 9999 not seen");
  a_mode_bits_kept: assert property (
    state == st_exec && (cmd.dst_mem || cmd.dst_reg != `CCCB_SR)
    |=> regs[`CCCB_SR][`CCCB_MODE_HI:`CCCB_MODE_LO]
        == $past(regs[`CCCB_SR][`CCCB_MODE_HI:`CCCB_MODE_LO]))
    else $error("mode bits changed");
  a_byte_lane: assert property (
    mem_valid && mem_req.we && cmd.byte_op && state == st_write
    |-> mem_req.be == (mem_req.addr[0] ? 2'b10 : 2'b01))
    else $error("byte write enabled the wrong lane");
  a_clr_flags_kept: assert property (
    state == st_exec && cmd.op == op_zero_destination
    && (cmd.dst_mem || cmd.dst_reg != `CCCB_SR)
    |=> regs[`CCCB_SR] == $past(regs[`CCCB_SR]))
    else $error("clear altered status word");
  a_cmp_carry_word: assert property (
    state == st_exec && cmd.op == op_compare_op && !cmd.byte_op
    |=> regs[`CCCB_SR][`CCCB_SR_C] == ($past(dop) >= $past(tmp)))
    else $error("compare carry does not match unsigned order");
  a_cmp_dst_kept: assert property (
    state == st_exec && cmd.op == op_compare_op && !cmd.dst_mem && cmd.dst_reg != `CCCB_SR
    |=> regs[cmd.dst_reg] == $past(regs[cmd.dst_reg]))
    else $error("compare changed its destination register");
endmodule

// >>> dv/cccb_mem_model.sv
// behavioural program and data memory seen over the core's memory bus
`timescale 1ns/1ps
module cccb_mem_model
  import cccb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mem_valid,
  input wire cccb_mem_t mem_req,
  output logic mem_ready,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:511];
  logic [15:0] last;
  logic [1:0] wait_cnt;
  logic [8:0] idx;
  assign idx = mem_req.addr[9:1];
  // slow mode holds off two cycles per access
  assign mem_ready = mem_valid & (~slow | (wait_cnt == 2'h2));
  // idle bus shows the inverse of the last word, so stale data never passes
  assign mem_rdata = (mem_valid & mem_ready & ~mem_req.we) ? mem[idx] : ~last;
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 2'h0;
      last <= 16'h0000;
    end else if (mem_valid & mem_ready) begin
      wait_cnt <= 2'h0;
      last <= mem_req.we ? mem_req.wdata : mem_rdata;
      if (mem_req.we & mem_req.be[0]) mem[idx][7:0] <= mem_req.wdata[7:0];
      if (mem_req.we & mem_req.be[1]) mem[idx][15:8] <= mem_req.wdata[15:8];
    end else if (mem_valid) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// >>> dv/test_cpu_call_compare_bcd_ops.sv
// self-checking bench for the call, compare and decimal add core slice
`timescale 1ns/1ps
`include "cccb_map.svh"
module test_cpu_call_compare_bcd_ops;
  import cccb_pkg::*;
  typedef struct packed {
    logic [19:0] r4, r5, pc;
    logic [15:0] srcx;
    logic [19:0] sr;
    logic [16:0] cmd;
    logic [3:0] chk;
    logic [19:0] exp, exp_sr;
  } cccb_row_t;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic pready, pslverr, mem_valid, mem_ready, busy, e;
  logic [15:0] mem_rdata;
  cccb_mem_t mem_req;
  int bad_count = 0, total_checks = 0, cycles = 0;
  cccb_row_t rows [0:17] = '{
    '{20'h5, 20'ha0005, 20'h0, 16'h0, 20'h38, 17'h05407, 4'h5, 20'ha0005, 20'h3b},
    '{20'h1, 20'h57f80, 20'h0, 16'h0, 20'h07, 17'h05417, 4'h5, 20'h57f80, 20'h101},
    '{20'h2, 20'h00001, 20'h0, 16'h0, 20'h139, 17'h05407, 4'h5, 20'h00001, 20'h3c},
    '{20'h1234, 20'hf4321, 20'h0, 16'h0, 20'h39, 17'h05409, 4'h5, 20'h05556, 20'h38},
    '{20'h1, 20'h09999, 20'h0, 16'h0, 20'h100, 17'h05409, 4'h5, 20'h0, 20'h103},
    '{20'h45, 20'h12345, 20'h0, 16'h0, 20'h01, 17'h05419, 4'h5, 20'h00091, 20'h04},
    '{20'h1111, 20'h09999, 20'h0, 16'h0, 20'h01, 17'h05408, 4'h5, 20'h0, 20'h03},
    '{20'h0, 20'h00099, 20'h0, 16'h0, 20'h02, 17'h05418, 4'h5, 20'h00099, 20'h04},
    '{20'h0, 20'h12345, 20'h0, 16'h0, 20'h107, 17'h05403, 4'h5, 20'h0, 20'h107},
    '{20'h0, 20'h12345, 20'h0, 16'h0, 20'h13f, 17'h05404, 4'h5, 20'h12345, 20'h13e},
    '{20'h0, 20'h12345, 20'h0, 16'h0, 20'h13f, 17'h05405, 4'h5, 20'h12345, 20'h13b},
    '{20'h0, 20'h12345, 20'h0, 16'h0, 20'h13f, 17'h05406, 4'h5, 20'h12345, 20'h13d},
    '{20'h1234, 20'h0, 20'h30000, 16'h0, 20'h13f, 17'h05401, 4'h0, 20'h01234, 20'h13f},
    '{20'h2abcd, 20'h0, 20'h0, 16'h0, 20'h13f, 17'h05402, 4'h0, 20'h0abcd, 20'h13f},
    '{20'h0, 20'h0, 20'h0, 16'haa04, 20'h13f, 17'h054c2, 4'h0, 20'h0aa04, 20'h13f},
    '{20'h0, 20'h0, 20'h0, 16'h0100, 20'h13f, 17'h05462, 4'h0, 20'h0beef, 20'h13f},
    '{20'h100, 20'h0, 20'h0, 16'h0, 20'h13f, 17'h05482, 4'h0, 20'h0beef, 20'h13f},
    '{20'h300, 20'h0, 20'h0, 16'hfffe, 20'h13f, 17'h05422, 4'h0, 20'h04444, 20'h13f}
  };
  always #2.5 clk = ~clk;
  cccb_core uut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .busy(busy));
  cccb_mem_model mem_i (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_valid(mem_valid),
    .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered and left just after a rising edge; one idle cycle after each access
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, d, r, x);
  endtask
  task automatic setr(input logic [3:0] n, input logic [19:0] d);
    wr({`CCCB_REG_PAGE, n, 2'b00}, {12'h0, d});
  endtask
  task automatic getr(input logic [3:0] n, output logic [31:0] d);
    apb(1'b0, {`CCCB_REG_PAGE, n, 2'b00}, 32'h0, d, e);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    check({31'h0, busy}, 32'h0);
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    // a full run needs well under a thousand cycles
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mem_i.mem[9'h080] = 16'hbeef;
    mem_i.mem[9'h081] = 16'h5678;
    mem_i.mem[9'h17f] = 16'h4444;
    mem_i.mem[9'h100] = 16'ha55a;
    mem_i.mem[9'h101] = 16'h9999;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    getr(4'h5, v);
    check(v, 32'h0);
    apb(1'b0, `CCCB_STAT_OFF, 32'h0, v, e);
    check(v, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0, v, e);
    check({31'h0, e}, 32'h1);
    $display("reset and unmapped access done");
    setr(4'h1, 20'h00200);
    for (int i = 0; i < 18; i++) begin
      setr(4'h4, rows[i].r4);
      setr(4'h5, rows[i].r5);
      setr(4'h0, rows[i].pc);
      setr(4'h2, rows[i].sr);
      wr(`CCCB_SRCX_OFF, {16'h0, rows[i].srcx});
      wr(`CCCB_CMD_OFF, {15'h0, rows[i].cmd});
      wait_idle();
      getr(rows[i].chk, v);
      check(v, {12'h0, rows[i].exp});
      getr(4'h2, v);
      check(v, {12'h0, rows[i].exp_sr});
      $display("row %0d done", i);
    end
    slow <= 1'b1;
    setr(4'h4, 20'h00100);
    setr(4'h1, 20'h00200);
    setr(4'h0, 20'h3abcd);
    setr(4'h2, 20'h0013f);
    wr(`CCCB_SRCX_OFF, 32'h0);
    wr(`CCCB_CMD_OFF, 32'h054a2);
    apb(1'b1, `CCCB_SRCX_OFF, 32'h1, v, e);
    check({31'h0, e}, 32'h1);
    wait_idle();
    apb(1'b0, `CCCB_SRCX_OFF, 32'h0, v, e);
    check(v, 32'h0);
    getr(4'h0, v);
    check(v, 32'h0beef);
    getr(4'h4, v);
    check(v, 32'h00102);
    getr(4'h1, v);
    check(v, 32'h001fe);
    check({16'h0, mem_i.mem[9'h0ff]}, 32'habcd);
    getr(4'h2, v);
    check(v, 32'h0013f);
    $display("slow call done");
    slow <= 1'b0;
    wr(`CCCB_CMD_OFF, 32'h054a1);
    wait_idle();
    getr(4'h0, v);
    check(v, 32'h05678);
    getr(4'h4, v);
    check(v, 32'h00104);
    setr(4'h6, 20'h00200);
    wr(`CCCB_DSTX_OFF, 32'h1);
    wr(`CCCB_CMD_OFF, 32'h16013);
    wait_idle();
    check({16'h0, mem_i.mem[9'h100]}, 32'h005a);
    setr(4'h4, 20'h0);
    wr(`CCCB_DSTX_OFF, 32'h0);
    wr(`CCCB_CMD_OFF, 32'h16007);
    wait_idle();
    check({16'h0, mem_i.mem[9'h100]}, 32'h005a);
    getr(4'h2, v);
    check(v, 32'h0003c);
    setr(4'h2, 20'h00001);
    wr(`CCCB_DSTX_OFF, 32'h2);
    wr(`CCCB_CMD_OFF, 32'h16008);
    wait_idle();
    check({16'h0, mem_i.mem[9'h101]}, 32'h0);
    getr(4'h2, v);
    check(v, 32'h00003);
    $display("jump and memory destination done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    getr(4'h6, v);
    check(v, 32'h0);
    apb(1'b0, `CCCB_STAT_OFF, 32'h0, v, e);
    check(v, 32'h0);
    $display("mid-run reset done");
    finish_test();
  end
endmodule
